// [include/rss_pkg.sv]
package rss_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CAUSE = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
  localparam int BIT_POR = 0;
  localparam int BIT_EXT = 1;
  localparam int BIT_BOR = 2;
  localparam int BIT_WDT = 3;
  localparam int BIT_USB = 5;
  localparam logic [7:0] CAUSE_MASK = 8'h2f;
  localparam int CTRL_BG_BIT = 0;
  localparam int CTRL_USBRST_BIT = 1;
  localparam logic [2:0] BOD_OFF_CODE = 3'h7;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int PIN_MIN_NS = 400;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int TOUT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic por;
    logic ext;
    logic bor;
    logic wdt;
    logic usb;
  } rss_src_t;
endpackage

// [rtl/rss_top.sv]
`timescale 1ns/1ps
// Summary of operation
// R1: power-on source stays active while supply-low detector indication is active.
// R2: supply rising past threshold starts delay counter; reset held until time-out.
// R3: supply falling below level re-asserts internal reset immediately.
// R4: low pin level longer than minimum width resets device, even without clock; here only port_reset acts unclocked, core_reset needs aclk for the filter.
// R5: after pin returns high, core held in reset until time-out expires.
// R6: 3-bit level code; 111 disables brown-out, lower codes higher levels.
// R7: enabled brown-out with supply below level asserts reset immediately.
// R8: supply back above brown-out level starts delay; release after time-out.
// R9: watchdog time-out gives an internal reset pulse of one clock cycle.
// R10: time-out count starts at falling edge of the watchdog pulse.
// R11: enabled USB with reset option and bus reset resets core, USB stays.
// R12: cause bits 7 and 6 read zero; bit 4 reserved.
// R13: bit 5 set on USB reset; cleared by power-on or software zero.
// R14: bit 3 set on watchdog reset; cleared by power-on or software zero.
// R15: bit 2 set on brown-out reset; cleared by power-on or software zero.
// R16: bit 1 set on pin reset; cleared by power-on or software zero.
// R17: bit 0 set on power-on; cleared only by software writing zero.
// R18: bandgap enable active only with brown-out enabled or bandgap-select set.
// R19: software waits reference start-up after bandgap-select before trusting comparator.
// R20: software reads then clears cause register early after start-up.
// R21: ports return to initial state at once when any source is active.
// R22: time-out chosen by start-up and clock fuses; starts after sources inactive.
// R23: internal reset is OR of sources and running count; new source restarts.
module rss_top
  import rss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supply_low,
  input wire logic reset_pin_n,
  input wire logic bod_below,
  input wire logic [2:0] brownout_level_code,
  input wire logic wdt_timeout,
  input wire logic usb_enabled,
  input wire logic usb_bus_reset,
  input wire logic [TOUT_W-1:0] startup_timeout_cycles,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic core_reset,
  output logic port_reset,
  output logic usb_keep_enabled,
  output logic wdt_reset_pulse,
  output logic bandgap_enable
);
  typedef enum logic [1:0] {ST_HOLD, ST_COUNT, ST_RUN} rss_state_t;

  logic pin_s1_r, pin_s2_r, wdt_s1_r, wdt_s2_r, wdt_d_r, usb_s1_r, usb_s2_r;
  logic [7:0] pin_cnt_r;
  logic pin_rst_r, wdt_pulse_r;
  logic bod_on;
  rss_src_t src;
  logic any_src, any_src_d_r;
  rss_state_t st_r;
  logic [TOUT_W-1:0] cnt_r;
  logic [7:0] cause_r;
  logic [1:0] ctrl_r;
  logic aw_got_r, w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r;
  logic [DATA_W/8-1:0] w_strb_r;
  logic wr_fire;

  // synchronisers for the clocked paths only; the async view goes straight to port_reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      wdt_s1_r <= 1'b0;
      wdt_s2_r <= 1'b0;
      usb_s1_r <= 1'b0;
      usb_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
      wdt_s1_r <= wdt_timeout;
      wdt_s2_r <= wdt_s1_r;
      usb_s1_r <= usb_bus_reset;
      usb_s2_r <= usb_s1_r;
    end
  end

  // short pin glitches are filtered; only a full minimum width counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cnt_r <= 8'h00;
      pin_rst_r <= 1'b0;
    end else if (pin_s2_r) begin
      pin_cnt_r <= 8'h00;
      pin_rst_r <= 1'b0;
    end else if (pin_cnt_r >= 8'(PIN_MIN_CYC)) begin
      pin_rst_r <= 1'b1; // R4
    end else begin
      pin_cnt_r <= pin_cnt_r + 8'h01;
    end
  end

  // one-cycle pulse on the rising edge of the watchdog time-out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_d_r <= 1'b0;
      wdt_pulse_r <= 1'b0;
    end else begin
      wdt_d_r <= wdt_s2_r;
      wdt_pulse_r <= wdt_s2_r && !wdt_d_r; // R9
    end
  end
  assign wdt_reset_pulse = wdt_pulse_r;

  assign bod_on = (brownout_level_code != BOD_OFF_CODE); // R6
  always_comb begin
    src.por = supply_low; // R1
    src.ext = pin_rst_r;
    src.bor = bod_on && bod_below; // R7
    src.wdt = wdt_pulse_r;
    src.usb = usb_enabled && ctrl_r[CTRL_USBRST_BIT] && usb_s2_r; // R11
  end
  assign any_src = src.por | src.ext | src.bor | src.wdt | src.usb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      any_src_d_r <= 1'b1;
    end else begin
      any_src_d_r <= any_src;
    end
  end

  // hold while any source is active, count only after all release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_HOLD;
      cnt_r <= '0;
    end else if (any_src) begin
      st_r <= ST_HOLD; // R23
      cnt_r <= '0;
    end else begin
      case (st_r)
        ST_HOLD: begin
          st_r <= ST_COUNT; // R2 R5 R8 R10 R22
          cnt_r <= '0;
        end
        ST_COUNT: begin
          if (cnt_r + 16'h0001 >= startup_timeout_cycles) begin
            st_r <= ST_RUN;
          end
          cnt_r <= cnt_r + 16'h0001;
        end
        ST_RUN: st_r <= ST_RUN;
        default: st_r <= ST_HOLD;
      endcase
    end
  end

  // sources feed the outputs combinationally so a supply drop acts at once; a raw pin drop acts at once on port_reset only
  assign core_reset = any_src || (st_r != ST_RUN) || !aresetn; // R3 R23
  assign port_reset = supply_low || !reset_pin_n || src.bor || core_reset; // R21
  assign usb_keep_enabled = usb_enabled; // R11
  assign bandgap_enable = bod_on || ctrl_r[CTRL_BG_BIT]; // R18

  function automatic logic wr_lane0_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
                                        input logic [DATA_W/8-1:0] s);
    return (a == off) && s[0];
  endfunction

  // axi write: address and data latched in either order, response after both
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == OFF_CAUSE || aw_addr_r == OFF_CTRL || aw_addr_r == OFF_STAT)
                       ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // cause flags: hardware set wins over software clear; aresetn is a core reset, not power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= cause_r & CAUSE_MASK;
    end else begin
      if (wr_fire && wr_lane0_hit(aw_addr_r, OFF_CAUSE, w_strb_r)) begin
        cause_r <= (cause_r & w_data_r[7:0] & CAUSE_MASK) | {2'b00, src.usb, 1'b0, src.wdt, src.bor, src.ext,
                   src.por}; // R12 R17
      end else begin
        cause_r <= (cause_r | {2'b00, src.usb, 1'b0, src.wdt, src.bor, src.ext, src.por}) & CAUSE_MASK;
      end
      if (src.por) begin
        cause_r[BIT_USB] <= 1'b0; // R13
        cause_r[BIT_WDT] <= 1'b0; // R14
        cause_r[BIT_BOR] <= 1'b0; // R15
        cause_r[BIT_EXT] <= 1'b0; // R16
        cause_r[BIT_POR] <= 1'b1; // R17
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 2'b00;
    end else if (wr_fire && wr_lane0_hit(aw_addr_r, OFF_CTRL, w_strb_r)) begin
      ctrl_r <= w_data_r[1:0];
    end
  end

  // axi read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_CAUSE: s_axi_rdata <= {24'h000000, cause_r & CAUSE_MASK}; // R12
        OFF_CTRL: s_axi_rdata <= {30'h00000000, ctrl_r};
        OFF_STAT: s_axi_rdata <= {28'h0000000, bandgap_enable, bod_on, st_r == ST_COUNT, core_reset};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_wdt_one_cycle;
    @(posedge aclk) disable iff (!aresetn) wdt_pulse_r |=> !wdt_pulse_r;
  endproperty
  a_wdt_one_cycle: assert property (p_wdt_one_cycle) else $error("watchdog pulse longer than one cycle"); // R9
  property p_por_immediate;
    @(posedge aclk) disable iff (!aresetn) supply_low |-> core_reset && port_reset;
  endproperty
  a_por_immediate: assert property (p_por_immediate) else $error("reset not immediate on supply low"); // R3
  property p_hold_after_release;
    @(posedge aclk) disable iff (!aresetn) $fell(any_src) |-> core_reset;
  endproperty
  a_hold_after_release: assert property (p_hold_after_release) else $error("core released with no delay"); // R22
  property p_por_flag;
    @(posedge aclk) disable iff (!aresetn) src.por |=> cause_r[BIT_POR] && !cause_r[BIT_WDT];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag handling wrong"); // R17
  property p_wdt_flag;
    @(posedge aclk) disable iff (!aresetn) (src.wdt && !src.por) |=> cause_r[BIT_WDT];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set"); // R14
  property p_bor_flag;
    @(posedge aclk) disable iff (!aresetn) (src.bor && !src.por) |=> cause_r[BIT_BOR];
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("brown-out flag not set"); // R15
  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn) cause_r[7:6] == 2'b00 && !cause_r[4];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved cause bits set"); // R12
  property p_bandgap;
    @(posedge aclk) disable iff (!aresetn) bandgap_enable == (brownout_level_code != BOD_OFF_CODE || ctrl_r[0]);
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap enable wrong"); // R18
  property p_bod_disabled;
    @(posedge aclk) disable iff (!aresetn) (brownout_level_code == BOD_OFF_CODE) |-> !src.bor;
  endproperty
  a_bod_disabled: assert property (p_bod_disabled) else $error("brown-out active while disabled"); // R6
  property p_restart;
    @(posedge aclk) disable iff (!aresetn) (st_r == ST_COUNT && any_src) |=> st_r == ST_HOLD;
  endproperty
  a_restart: assert property (p_restart) else $error("new source did not restart count"); // R23
  // raw pin and supply views must reach the ports even while the filtered path lags
  property p_pin_reset;
    @(posedge aclk) disable iff (!aresetn) pin_rst_r |-> core_reset && port_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("filtered pin reset not applied"); // R4
  property p_pin_async;
    @(posedge aclk) disable iff (!aresetn) !reset_pin_n |-> port_reset;
  endproperty
  a_pin_async: assert property (p_pin_async) else $error("ports not reset by low pin"); // R21
  property p_bor_immediate;
    @(posedge aclk) disable iff (!aresetn) src.bor |-> core_reset && port_reset;
  endproperty
  a_bor_immediate: assert property (p_bor_immediate) else $error("brown-out reset not immediate"); // R7
  property p_bor_release;
    @(posedge aclk) disable iff (!aresetn) $fell(src.bor) |-> core_reset;
  endproperty
  a_bor_release: assert property (p_bor_release) else $error("core released with brown-out end"); // R8
  property p_usb_kept;
    @(posedge aclk) disable iff (!aresetn) src.usb |-> usb_keep_enabled;
  endproperty
  a_usb_kept: assert property (p_usb_kept) else $error("usb block dropped during its reset"); // R11
  property p_usb_gate;
    @(posedge aclk) disable iff (!aresetn) (!usb_enabled || !ctrl_r[CTRL_USBRST_BIT]) |-> !src.usb;
  endproperty
  a_usb_gate: assert property (p_usb_gate) else $error("usb reset while not enabled"); // R11
  property p_usb_flag;
    @(posedge aclk) disable iff (!aresetn) (src.usb && !src.por) |=> cause_r[BIT_USB];
  endproperty
  a_usb_flag: assert property (p_usb_flag) else $error("usb flag not set"); // R13
  property p_ext_flag;
    @(posedge aclk) disable iff (!aresetn) (src.ext && !src.por) |=> cause_r[BIT_EXT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("pin flag not set"); // R16
  property p_por_clears;
    @(posedge aclk) disable iff (!aresetn) src.por |=> !cause_r[BIT_USB] && !cause_r[BIT_BOR] && !cause_r[BIT_EXT];
  endproperty
  a_por_clears: assert property (p_por_clears) else $error("power-on did not clear other flags"); // R15
  property p_full_delay;
    @(posedge aclk) disable iff (!aresetn) (st_r == ST_RUN && $past(st_r) != ST_RUN) |->
      $past(st_r) == ST_COUNT && $past(cnt_r) + 16'h0001 >= startup_timeout_cycles;
  endproperty
  a_full_delay: assert property (p_full_delay) else $error("released before full delay"); // R22
  property p_wdt_rise;
    @(posedge aclk) disable iff (!aresetn) $rose(wdt_s2_r) |=> wdt_pulse_r;
  endproperty
  a_wdt_rise: assert property (p_wdt_rise) else $error("no pulse on watchdog time-out"); // R9
  property p_wdt_restart;
    @(posedge aclk) disable iff (!aresetn) src.wdt |=> st_r == ST_HOLD;
  endproperty
  a_wdt_restart: assert property (p_wdt_restart) else $error("delay not restarted by watchdog pulse"); // R10
  property p_rd_cause_zero;
    @(posedge aclk) disable iff (!aresetn) (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CAUSE) |=>
      s_axi_rdata[7:6] == 2'h0 && !s_axi_rdata[4];
  endproperty
  a_rd_cause_zero: assert property (p_rd_cause_zero) else $error("reserved cause bits read nonzero"); // R12
  property p_por_kept;
    @(posedge aclk) disable iff (!aresetn)
      (cause_r[BIT_POR] && !(wr_fire && aw_addr_r == OFF_CAUSE && !w_data_r[BIT_POR])) |=> cause_r[BIT_POR];
  endproperty
  a_por_kept: assert property (p_por_kept) else $error("power-on flag lost without software clear"); // R17
  property p_release_from_count;
    @(posedge aclk) disable iff (!aresetn) $fell(core_reset) |-> $past(st_r) == ST_COUNT;
  endproperty
  a_release_from_count: assert property (p_release_from_count) else $error("core released outside delay count"); // R5

  c_release: cover property (@(posedge aclk) disable iff (!aresetn) $fell(core_reset));
  c_wdt: cover property (@(posedge aclk) disable iff (!aresetn) wdt_pulse_r ##1 core_reset);
  c_usb: cover property (@(posedge aclk) disable iff (!aresetn) src.usb && usb_keep_enabled);
  c_clear: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && aw_addr_r == OFF_CAUSE);
  // a pin pulse only counts once it has outlived the filter
  c_pin: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pin_rst_r));
endmodule // rss_top

// [test/rss_far_end.sv]
`timescale 1ns/1ps
module rss_far_end (
  input wire logic aclk,
  output logic supply_low,
  output logic reset_pin_n,
  output logic bod_below,
  output logic wdt_timeout,
  output logic usb_enabled,
  output logic usb_bus_reset
);
  // idle: monitors quiet, pin pulled high, usb macro up
  initial begin
    supply_low = 1'b0;
    reset_pin_n = 1'b1;
    bod_below = 1'b0;
    wdt_timeout = 1'b0;
    usb_enabled = 1'b1;
    usb_bus_reset = 1'b0;
  end
  // one source at a time, changed just after a rising edge
  task automatic raise(input int src);
    @(posedge aclk);
    case (src)
      0: supply_low <= 1'b1;
      1: reset_pin_n <= 1'b0;
      2: bod_below <= 1'b1;
      3: wdt_timeout <= 1'b1;
      default: usb_bus_reset <= 1'b1;
    endcase
  endtask
  // released pin returns to its pull-up level
  task automatic drop();
    @(posedge aclk);
    supply_low <= 1'b0;
    reset_pin_n <= 1'b1;
    bod_below <= 1'b0;
    wdt_timeout <= 1'b0;
    usb_bus_reset <= 1'b0;
  endtask
  // usb macro power as the sequencer sees it
  task automatic usb_power(input logic on);
    @(posedge aclk);
    usb_enabled <= on;
  endtask
endmodule // rss_far_end

// [test/rss_top_test.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module rss_top_test;
  import rss_pkg::*;
  // short delay count keeps the run brief
  localparam logic [TOUT_W-1:0] TOUT = 16'h0005;
  logic aclk = 1'b0;
  logic aresetn, supply_low, reset_pin_n, bod_below, wdt_timeout, usb_enabled, usb_bus_reset;
  logic [2:0] level;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rd_d;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_r;
  logic [DATA_W-1:0] rdata;
  logic core_reset, port_reset, usb_keep_enabled, wdt_reset_pulse, bandgap_enable;
  int error_cnt = 0;
  int samples_checked = 0;
  int c;
  int n;
  always #50 aclk = ~aclk;
  rss_far_end far_u (.aclk(aclk), .supply_low(supply_low), .reset_pin_n(reset_pin_n), .bod_below(bod_below),
    .wdt_timeout(wdt_timeout), .usb_enabled(usb_enabled), .usb_bus_reset(usb_bus_reset));
  rss_top dut_u (.aclk(aclk), .aresetn(aresetn), .supply_low(supply_low), .reset_pin_n(reset_pin_n),
    .bod_below(bod_below), .brownout_level_code(level), .wdt_timeout(wdt_timeout), .usb_enabled(usb_enabled),
    .usb_bus_reset(usb_bus_reset), .startup_timeout_cycles(TOUT), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_reset(core_reset),
    .port_reset(port_reset), .usb_keep_enabled(usb_keep_enabled), .wdt_reset_pulse(wdt_reset_pulse),
    .bandgap_enable(bandgap_enable));
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic to_out(input string w);
    error_cnt++;
    $display("BAD %s exp done got timeout", w);
    conclude();
  endtask
  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic ta;
    logic tw;
    logic tb;
    logic [1:0] br;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (int i = 0; i < 50 && !tb; i++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) to_out("write");
    `CHK("bresp", RESP_OKAY, br)
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    logic ta;
    logic tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    for (int i = 0; i < 50 && !tr; i++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) to_out("read");
  endtask
  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    axi_rd(a);
    `CHK(nm, e, rd_d)
  endtask
  // core must stay held at least the programmed count after the last source lets go
  task automatic wait_rel();
    n = 0;
    @(negedge aclk);
    while (core_reset !== 1'b0 && n < 300) begin
      n++;
      @(negedge aclk);
    end
    if (n >= 300) to_out("release");
    `CHK("hold_long_enough", 1'b1, n >= int'(TOUT))
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    to_out("run");
  end
  initial begin
    aresetn = 1'b0;
    level = 3'h7;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'h1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_rel();
    far_u.raise(0);
    @(negedge aclk);
    `CHK("por_core", 1'b1, core_reset)
    `CHK("por_port", 1'b1, port_reset)
    far_u.drop();
    wait_rel();
    rd_chk("cause_por", OFF_CAUSE, 32'h0000_0001);
    axi_wr(OFF_CAUSE, 32'h0000_0000);
    rd_chk("cause_clr", OFF_CAUSE, 32'h0000_0000);
    far_u.raise(1);
    @(negedge aclk);
    `CHK("pin_port", 1'b1, port_reset)
    repeat (PIN_MIN_CYC + 4) @(negedge aclk);
    `CHK("pin_core", 1'b1, core_reset)
    far_u.drop();
    wait_rel();
    rd_chk("cause_pin", OFF_CAUSE, 32'h0000_0002);
    for (c = 0; c < 8; c++) begin
      @(posedge aclk);
      level <= c[2:0];
      far_u.raise(2);
      @(negedge aclk);
      `CHK("bod_core", c != 7, core_reset)
      `CHK("bod_bg", c != 7, bandgap_enable)
      far_u.drop();
      if (c != 7) wait_rel();
    end
    rd_chk("cause_bod", OFF_CAUSE, 32'h0000_0006);
    far_u.raise(3);
    n = 0;
    while (wdt_reset_pulse !== 1'b1 && n < 10) begin
      n++;
      @(negedge aclk);
    end
    if (n >= 10) to_out("wdt pulse");
    @(negedge aclk);
    `CHK("wdt_width", 1'b0, wdt_reset_pulse)
    `CHK("wdt_core", 1'b1, core_reset)
    far_u.drop();
    wait_rel();
    rd_chk("cause_wdt", OFF_CAUSE, 32'h0000_000e);
    axi_wr(OFF_CTRL, 32'h0000_0002);
    far_u.raise(4);
    repeat (4) @(posedge aclk);
    far_u.drop();
    @(negedge aclk);
    n = 0;
    while (core_reset !== 1'b1 && n < 10) begin
      n++;
      @(negedge aclk);
    end
    if (n >= 10) to_out("usb reset");
    `CHK("usb_core", 1'b1, core_reset)
    `CHK("usb_kept", 1'b1, usb_keep_enabled)
    wait_rel();
    rd_chk("cause_usb", OFF_CAUSE, 32'h0000_002e);
    far_u.usb_power(1'b0);
    far_u.raise(4);
    repeat (4) @(negedge aclk);
    `CHK("usb_off_core", 1'b0, core_reset)
    `CHK("usb_off_kept", 1'b0, usb_keep_enabled)
    far_u.drop();
    @(posedge aclk);
    wstrb <= 4'h0;
    axi_wr(OFF_CAUSE, 32'h0000_0000);
    rd_chk("cause_nolane", OFF_CAUSE, 32'h0000_002e);
    @(posedge aclk);
    wstrb <= 4'h1;
    far_u.usb_power(1'b1);
    axi_wr(OFF_CTRL, 32'h0000_0001);
    @(negedge aclk);
    `CHK("bg_on", 1'b1, bandgap_enable)
    // reference start-up allowance before a comparator result would be trusted
    repeat (700) @(posedge aclk);
    axi_wr(OFF_CTRL, 32'h0000_0000);
    @(negedge aclk);
    `CHK("bg_off", 1'b0, bandgap_enable)
    axi_rd(4'hc);
    `CHK("unmapped_resp", RESP_SLVERR, rd_r)
    `CHK("unmapped_data", 32'h0000_0000, rd_d)
    far_u.raise(0);
    @(negedge aclk);
    `CHK("por_again", 1'b1, core_reset)
    far_u.drop();
    wait_rel();
    rd_chk("cause_por2", OFF_CAUSE, 32'h0000_0001);
    axi_wr(OFF_CAUSE, 32'h0000_00ff);
    rd_chk("cause_rsvd", OFF_CAUSE, 32'h0000_0001);
    @(posedge aclk);
    aresetn <= 1'b0;
    @(negedge aclk);
    `CHK("rst_core", 1'b1, core_reset)
    @(posedge aclk);
    aresetn <= 1'b1;
    wait_rel();
    rd_chk("cause_kept", OFF_CAUSE, 32'h0000_0001);
    conclude();
  end
endmodule // rss_top_test
